// ---- hw/fpct_top.sv ----
`timescale 1ns/10ps
module fpct_top #(
    parameter int          CLK_HZ   = 125_000_000,
    parameter logic [7:0]  MAKER_ID = fpct_pkg::MAKER_ID_DEF,
    parameter logic [7:0]  DIE_REV  = fpct_pkg::DIE_REV_DEF
) (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [fpct_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [fpct_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [fpct_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [fpct_pkg::AXI_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    output logic                                 conv_start,
    output logic                                 conv_busy,
    output logic                                 fan_pwm
);
    import fpct_pkg::*;

    localparam int FAST_DIV  = CLK_HZ / FAST_CLK_HZ;
    localparam int SLOW_DIV  = CLK_HZ / SLOW_CLK_HZ;
    localparam int HIRES_DIV = CLK_HZ / ((FAST_CLK_HZ / (2 * int'(HIRES_CODE))) * HIRES_STEPS);

    generate
        if (HIRES_DIV < 1) begin : g_bad_clk
            $error("CLK_HZ too low for the hires pwm tick");
        end
    endgenerate

    logic [31:0]            period_tbl [0:RATE_CODES-1];
    genvar g;
    generate
        for (g = 0; g < RATE_CODES; g++) begin : g_period
            assign period_tbl[g] = 32'((longint'(CLK_HZ) * MHZ_PER_HZ) / longint'(RATE_MHZ[g]));
        end
    endgenerate

    logic                   aw_hold_reg, aw_hold_next;
    logic [IDX_W-1:0]       aw_idx_reg, aw_idx_next;
    logic                   aw_bad_reg, aw_bad_next;
    logic                   w_hold_reg, w_hold_next;
    logic [7:0]             w_byte_reg, w_byte_next;
    logic                   w_lane_reg, w_lane_next;
    logic                   awready_reg, awready_next;
    logic                   wready_reg, wready_next;
    logic                   bvalid_reg, bvalid_next;
    logic [1:0]             bresp_reg, bresp_next;
    logic                   arready_reg, arready_next;
    logic                   rvalid_reg, rvalid_next;
    logic [1:0]             rresp_reg, rresp_next;
    logic [AXI_DATA_W-1:0]  rdata_reg, rdata_next;
    logic                   wr_fire;
    logic                   os_write;
    logic [IDX_W-1:0]       rd_idx;

    logic [RATE_W-1:0]      rate_code_reg, rate_code_next;
    logic                   standby_reg, standby_next;
    logic                   clk_slow_reg, clk_slow_next;
    logic                   hires_en_reg, hires_en_next;
    logic [FREQ_W-1:0]      freq_reg, freq_next;
    logic [DUTY_W-1:0]      duty_reg, duty_next;

    fpct_conv_state_t       state_reg, state_next;
    logic [31:0]            rate_cnt_reg, rate_cnt_next;
    logic [31:0]            conv_period;
    logic [6:0]             busy_cnt_reg, busy_cnt_next;
    logic                   pend_reg, pend_next;
    logic                   start_reg, start_next;
    logic [7:0]             count_reg, count_next;
    logic                   go;

    logic [31:0]            tick_cnt_reg, tick_cnt_next;
    logic [31:0]            tick_div;
    logic                   tick_reg, tick_next;
    fpct_pwm_cfg_t          pwm_cfg;

    // write channel: address and data are held independently, then committed together
    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_idx_next  = aw_idx_reg;
        aw_bad_next  = aw_bad_reg;
        w_hold_next  = w_hold_reg;
        w_byte_next  = w_byte_reg;
        w_lane_next  = w_lane_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        wr_fire      = aw_hold_reg && w_hold_reg && !bvalid_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_hold_next = 1'b1;
            aw_idx_next  = s_axi_awaddr[IDX_LSB +: IDX_W];
            aw_bad_next  = (s_axi_awaddr[AXI_ADDR_W-1:IDX_LSB+IDX_W] != '0);
        end
        if (s_axi_wvalid && wready_reg) begin
            w_hold_next = 1'b1;
            w_byte_next = s_axi_wdata[7:0];
            w_lane_next = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = RESP_OKAY;
            case (aw_idx_reg)
                IDX_CONFIG, IDX_RATE, IDX_STATUS, IDX_ONESHOT, IDX_ENH_CFG, IDX_PWM_CFG,
                IDX_DUTY, IDX_FREQ, IDX_MAKER, IDX_REV: bresp_next = RESP_OKAY;
                default: bresp_next = RESP_SLVERR;
            endcase
            if (aw_bad_reg) begin
                bresp_next = RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        awready_next = !aw_hold_next && !bvalid_next;
        wready_next  = !w_hold_next && !bvalid_next;
    end

    assign os_write = wr_fire && !aw_bad_reg && (aw_idx_reg == IDX_ONESHOT);

    // register file; byte lane 0 carries every writable register
    always_comb begin
        rate_code_next = rate_code_reg;
        standby_next   = standby_reg;
        clk_slow_next  = clk_slow_reg;
        hires_en_next  = hires_en_reg;
        freq_next      = freq_reg;
        duty_next      = duty_reg;
        if (wr_fire && !aw_bad_reg && w_lane_reg) begin
            case (aw_idx_reg)
                IDX_RATE:    rate_code_next = w_byte_reg[RATE_W-1:0];
                IDX_CONFIG:  standby_next   = w_byte_reg[STANDBY_BIT];
                IDX_PWM_CFG: clk_slow_next  = w_byte_reg[CLK_SEL_BIT];
                IDX_ENH_CFG: hires_en_next  = w_byte_reg[HIRES_BIT];
                IDX_FREQ:    freq_next      = w_byte_reg[FREQ_W-1:0];
                IDX_DUTY:    duty_next      = w_byte_reg;
                default:     ;
            endcase
        end
    end

    // read channel: one word per address handshake, answered the next cycle
    assign rd_idx = s_axi_araddr[IDX_LSB +: IDX_W];
    always_comb begin
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = '0;
            case (rd_idx)
                IDX_RATE:    rdata_next[RATE_W-1:0] = rate_code_reg;
                IDX_CONFIG:  rdata_next[STANDBY_BIT] = standby_reg;
                IDX_STATUS: begin
                    rdata_next[BUSY_BIT] = (state_reg == CONV_RUN);
                    rdata_next[PEND_BIT] = pend_reg;
                    rdata_next[COUNT_LSB +: 8] = count_reg;
                end
                IDX_ONESHOT: rdata_next = '0;
                IDX_ENH_CFG: rdata_next[HIRES_BIT] = hires_en_reg;
                IDX_PWM_CFG: rdata_next[CLK_SEL_BIT] = clk_slow_reg;
                IDX_DUTY:    rdata_next[DUTY_W-1:0] = duty_reg;
                IDX_FREQ:    rdata_next[FREQ_W-1:0] = freq_reg;
                IDX_MAKER:   rdata_next[7:0] = MAKER_ID;
                IDX_REV:     rdata_next[7:0] = DIE_REV;
                default:     rresp_next = RESP_SLVERR;
            endcase
            if (s_axi_araddr[AXI_ADDR_W-1:IDX_LSB+IDX_W] != '0) begin
                rresp_next = RESP_SLVERR;
                rdata_next = '0;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    always_comb begin
        if (hires_en_reg && !clk_slow_reg && freq_reg == HIRES_CODE) begin
            tick_div = 32'(HIRES_DIV);
        end else if (clk_slow_reg) begin
            tick_div = 32'(SLOW_DIV);
        end else begin
            tick_div = 32'(FAST_DIV);
        end
        tick_next     = (tick_cnt_reg >= tick_div - 32'h1);
        tick_cnt_next = tick_next ? 32'h0 : tick_cnt_reg + 32'h1;
    end

    assign conv_period = period_tbl[(rate_code_reg > RATE_TOP) ? int'(RATE_TOP)
                                                                : int'(rate_code_reg)];

    // conversion sequencer; a busy conversion delays a trigger rather than losing it
    always_comb begin
        state_next    = state_reg;
        busy_cnt_next = busy_cnt_reg;
        count_next    = count_reg;
        rate_cnt_next = standby_reg ? 32'h0 : rate_cnt_reg + 32'h1;
        go            = 1'b0;
        if (!standby_reg && rate_cnt_reg >= conv_period - 32'h1) begin
            rate_cnt_next = 32'h0;
            go            = 1'b1;
        end
        go        = go || (pend_reg && standby_reg);
        start_next = 1'b0;
        case (state_reg)
            CONV_IDLE: begin
                if (go) begin
                    state_next    = CONV_RUN;
                    busy_cnt_next = 7'(CONV_BUSY_CYCLES - 1);
                    start_next    = 1'b1;
                    count_next    = count_reg + 8'h01;
                end
            end
            CONV_RUN: begin
                busy_cnt_next = busy_cnt_reg - 7'h01;
                if (busy_cnt_reg == 7'h00) begin
                    state_next = CONV_IDLE;
                end
            end
            default: state_next = CONV_IDLE;
        endcase
        pend_next = (pend_reg && !(start_next && standby_reg)) || (os_write && standby_reg);
        if (!standby_reg && !os_write) begin
            pend_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            aw_idx_reg    <= '0;
            aw_bad_reg    <= 1'b0;
            w_hold_reg    <= 1'b0;
            w_byte_reg    <= 8'h00;
            w_lane_reg    <= 1'b0;
            awready_reg   <= 1'b0;
            wready_reg    <= 1'b0;
            bvalid_reg    <= 1'b0;
            bresp_reg     <= RESP_OKAY;
            arready_reg   <= 1'b0;
            rvalid_reg    <= 1'b0;
            rresp_reg     <= RESP_OKAY;
            rdata_reg     <= '0;
            rate_code_reg <= RATE_RESET;
            standby_reg   <= 1'b0;
            clk_slow_reg  <= 1'b0;
            hires_en_reg  <= 1'b0;
            freq_reg      <= FREQ_RESET;
            duty_reg      <= DUTY_RESET;
            state_reg     <= CONV_IDLE;
            rate_cnt_reg  <= 32'h0;
            busy_cnt_reg  <= 7'h00;
            pend_reg      <= 1'b0;
            start_reg     <= 1'b0;
            count_reg     <= 8'h00;
            tick_cnt_reg  <= 32'h0;
            tick_reg      <= 1'b0;
        end else begin
            aw_hold_reg   <= aw_hold_next;
            aw_idx_reg    <= aw_idx_next;
            aw_bad_reg    <= aw_bad_next;
            w_hold_reg    <= w_hold_next;
            w_byte_reg    <= w_byte_next;
            w_lane_reg    <= w_lane_next;
            awready_reg   <= awready_next;
            wready_reg    <= wready_next;
            bvalid_reg    <= bvalid_next;
            bresp_reg     <= bresp_next;
            arready_reg   <= arready_next;
            rvalid_reg    <= rvalid_next;
            rresp_reg     <= rresp_next;
            rdata_reg     <= rdata_next;
            rate_code_reg <= rate_code_next;
            standby_reg   <= standby_next;
            clk_slow_reg  <= clk_slow_next;
            hires_en_reg  <= hires_en_next;
            freq_reg      <= freq_next;
            duty_reg      <= duty_next;
            state_reg     <= state_next;
            rate_cnt_reg  <= rate_cnt_next;
            busy_cnt_reg  <= busy_cnt_next;
            pend_reg      <= pend_next;
            start_reg     <= start_next;
            count_reg     <= count_next;
            tick_cnt_reg  <= tick_cnt_next;
            tick_reg      <= tick_next;
        end
    end

    // hires only at fast clock, code 8
    assign pwm_cfg = '{freq_code: freq_reg, duty: duty_reg,
                       hires: hires_en_reg && !clk_slow_reg && (freq_reg == HIRES_CODE)};

    fpct_pwm u_pwm (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick_reg),
        .cfg     (pwm_cfg),
        .pwm_out (fan_pwm)
    );

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign conv_start    = start_reg;
    assign conv_busy     = (state_reg == CONV_RUN);

    sequence rd_of_s(logic [7:0] idx);
        s_axi_arvalid && arready_reg && (rd_idx == idx)
            && (s_axi_araddr[AXI_ADDR_W-1:IDX_LSB+IDX_W] == '0);
    endsequence

    sequence trigger_s;
        os_write && standby_reg && (state_reg == CONV_IDLE) && !pend_reg;
    endsequence

    rate_clamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rate_code_reg >= RATE_TOP) |-> (conv_period == period_tbl[RATE_CODES-1]))
        else $error("high rate code does not give the fastest rate");
    rate_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_of_s(IDX_RATE) |=> (rdata_reg[AXI_DATA_W-1:RATE_W] == '0))
        else $error("rate register upper bits not zero");
    rate_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (rate_code_reg == RATE_RESET))
        else $error("rate code not at reset value");
    one_shot_a: assert property (@(posedge aclk) disable iff (!aresetn)
        trigger_s |=> ##1 start_reg ##1 (!start_reg && conv_busy) [*8])
        else $error("one-shot did not start exactly one conversion");
    any_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (os_write && standby_reg) |=> (pend_reg || start_reg))
        else $error("one-shot write ignored");
    maker_id_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_of_s(IDX_MAKER) |=> (rvalid_reg && rdata_reg == {24'h0, MAKER_ID}))
        else $error("maker code wrong");
    die_rev_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_of_s(IDX_REV) |=> (rvalid_reg && rdata_reg == {24'h0, DIE_REV}))
        else $error("revision code wrong");
endmodule : fpct_top

// ---- hw/fpct_pkg.sv ----
package fpct_pkg;
    localparam int          AXI_ADDR_W   = 12;
    localparam int          AXI_DATA_W   = 32;
    localparam int          IDX_LSB      = 2;
    localparam int          IDX_W        = 8;
    // register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_CONFIG   = 8'h03;
    localparam logic [7:0]  IDX_RATE     = 8'h04;
    localparam logic [7:0]  IDX_STATUS   = 8'h08;
    localparam logic [7:0]  IDX_ONESHOT  = 8'h0F;
    localparam logic [7:0]  IDX_ENH_CFG  = 8'h45;
    localparam logic [7:0]  IDX_PWM_CFG  = 8'h4A;
    localparam logic [7:0]  IDX_DUTY     = 8'h4C;
    localparam logic [7:0]  IDX_FREQ     = 8'h4D;
    localparam logic [7:0]  IDX_MAKER    = 8'hFE;
    localparam logic [7:0]  IDX_REV      = 8'hFF;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // arbitrary identification values
    localparam logic [7:0]  MAKER_ID_DEF = 8'hA5;
    localparam logic [7:0]  DIE_REV_DEF  = 8'h3C;
    localparam int          STANDBY_BIT  = 6;
    localparam int          CLK_SEL_BIT  = 3;
    localparam int          HIRES_BIT    = 4;
    localparam int          BUSY_BIT     = 0;
    localparam int          PEND_BIT     = 1;
    localparam int          COUNT_LSB    = 8;
    localparam int          RATE_W       = 4;
    localparam logic [3:0]  RATE_RESET   = 4'h8;
    localparam logic [3:0]  RATE_TOP     = 4'h9;
    localparam int          RATE_CODES   = 10;
    // conversion rates in millihertz, codes 0 to 9
    localparam int          RATE_MHZ [0:RATE_CODES-1] =
        '{50, 100, 204, 406, 813, 1625, 3250, 6500, 13000, 26000};
    localparam longint      MHZ_PER_HZ   = 1000;
    localparam int          CONV_BUSY_CYCLES = 64;
    localparam int          FREQ_W       = 5;
    localparam int          DUTY_W       = 8;
    localparam int          STD_DUTY_W   = 6;
    localparam logic [4:0]  FREQ_RESET   = 5'h08;
    localparam logic [4:0]  HIRES_CODE   = 5'h08;
    localparam logic [7:0]  DUTY_RESET   = 8'h00;
    localparam logic [7:0]  HIRES_PERIOD = 8'hFF;
    localparam int          FAST_CLK_HZ  = 360_000;
    localparam int          SLOW_CLK_HZ  = 1_400;
    localparam int          HIRES_STEPS  = 255;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } fpct_conv_state_t;

    typedef struct packed {
        logic [FREQ_W-1:0] freq_code;
        logic [DUTY_W-1:0] duty;
        logic              hires;
    } fpct_pwm_cfg_t;
endpackage : fpct_pkg

// ---- hw/fpct_pwm.sv ----
`timescale 1ns/10ps
module fpct_pwm (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  tick,
    input  wire fpct_pkg::fpct_pwm_cfg_t cfg,
    output logic                       pwm_out
);
    import fpct_pkg::*;

    logic [7:0] period;
    logic [7:0] duty_eff;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       pwm_reg;
    logic       pwm_next;

    always_comb begin
        if (cfg.hires) begin
            period   = HIRES_PERIOD;
            duty_eff = cfg.duty;
        end else begin
            if (cfg.freq_code == '0) begin
                period = 8'h02;
            end else begin
                period = {2'h0, cfg.freq_code, 1'b0};
            end
            duty_eff = {2'h0, cfg.duty[STD_DUTY_W-1:0]};
        end
        cnt_next = cnt_reg;
        if (tick) begin
            cnt_next = (cnt_reg >= period - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
        end
        // duty at or above the period keeps the output high throughout
        pwm_next = (cnt_next < duty_eff);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
            pwm_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pwm_reg <= pwm_next;
        end
    end

    assign pwm_out = pwm_reg;

    sequence wrap_s;
        tick && !cfg.hires && (cnt_reg == period - 8'h01);
    endsequence

    pwm_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap_s |=> (cnt_reg == 8'h00))
        else $error("pwm counter did not wrap at twice the code");

    code_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!cfg.hires && cfg.freq_code == '0) |-> (period == 8'h02))
        else $error("code zero does not give the period of code one");

    hires_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg.hires && cfg.duty == HIRES_PERIOD && $stable(cfg)) |=> pwm_reg)
        else $error("full hires duty does not hold output high");
endmodule : fpct_pwm

// ---- tb/test_fan_pwm_and_conversion_timing.sv ----
`timescale 1ns/10ps
module test_fan_pwm_and_conversion_timing;
    import fpct_pkg::*;
    // reduced clock rate keeps pwm ticks short: 16 cycles per fast tick
    localparam int SIM_HZ = 6_000_000;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, cyc = '0, hic = '0, starts = '0, n0, v;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        conv_start, conv_busy, fan_pwm;
    logic [33:0] rq[$], e;
    logic [31:0] t1, h1;
    int          errors = 0, total_checks = 0, seed = 85422, k;

    fpct_top #(.CLK_HZ(SIM_HZ)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .conv_start, .conv_busy, .fan_pwm);

    initial begin
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 32'h1;
        hic <= hic + {31'h0, fan_pwm};
        starts <= starts + {31'h0, conv_start};
    end

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // the read monitor pairs each answer with the oldest queued note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            chk("read", e, {s_axi_rresp, s_axi_rdata});
        end
    end

    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction : ba

    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= ba(i);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {32'h0, r}, {32'h0, s_axi_bresp});
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [33:0] x);
        s_axi_araddr <= ba(i);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rq.push_back(x);
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic pwm_chk(input logic [4:0] c, input logic [7:0] d);
        logic [31:0] t0, h0, eff;
        eff = (c == 5'h0) ? 32'h1 : {27'h0, c};
        wr(IDX_FREQ, {27'h0, c}, RESP_OKAY);
        wr(IDX_DUTY, {24'h0, d}, RESP_OKAY);
        repeat (300) @(posedge aclk);
        @(posedge fan_pwm);
        t0 = cyc;
        h0 = hic;
        @(posedge fan_pwm);
        chk("pwm period", {2'h0, 2 * eff * (SIM_HZ / FAST_CLK_HZ)}, {2'h0, cyc - t0});
        chk("pwm duty", {2'h0, (cyc - t0) * d}, {2'h0, (hic - h0) * 2 * eff});
    endtask : pwm_chk

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(IDX_RATE, {RESP_OKAY, 32'h8});
        rd(IDX_MAKER, {RESP_OKAY, 24'h0, MAKER_ID_DEF});
        wr(IDX_REV, $random(seed), RESP_OKAY);
        rd(IDX_REV, {RESP_OKAY, 24'h0, DIE_REV_DEF});
        rd(8'h10, {RESP_SLVERR, 32'h0});
        $display("test identification done");
        for (k = 0; k < 6; k++) begin
            v = $random(seed);
            wr(IDX_RATE, v, RESP_OKAY);
            rd(IDX_RATE, {RESP_OKAY, 28'h0, v[3:0]});
        end
        $display("test rate field done");
        wr(IDX_CONFIG, 32'h40, RESP_OKAY);
        // a conversion already running would delay the triggered one
        for (k = 0; k < 100 && conv_busy !== 1'b0; k++) @(posedge aclk);
        n0 = starts;
        wr(IDX_ONESHOT, $random(seed), RESP_OKAY);
        repeat (150) @(posedge aclk);
        chk("conversions", {2'h0, n0 + 32'h1}, {2'h0, starts});
        rd(IDX_ONESHOT, {RESP_OKAY, 32'h0});
        $display("test one shot done");
        v = $random(seed);
        pwm_chk(5'h0, 8'h01);
        pwm_chk(5'h3, 8'h05);
        pwm_chk(5'h4, {5'h0, v[2:0]} | 8'h01);
        $display("test pwm done");
        // hires: fast clock, code 8, one tick per cycle at the bench clock rate
        wr(IDX_ENH_CFG, 32'h10, RESP_OKAY);
        wr(IDX_FREQ, 32'h8, RESP_OKAY);
        wr(IDX_DUTY, 32'h80, RESP_OKAY);
        repeat (600) @(posedge aclk);
        @(posedge fan_pwm);
        t1 = cyc;
        h1 = hic;
        @(posedge fan_pwm);
        chk("hires period", 34'h0FF, {2'h0, cyc - t1});
        chk("hires duty", 34'h080, {2'h0, hic - h1});
        wr(IDX_DUTY, 32'hFF, RESP_OKAY);
        repeat (300) @(posedge aclk);
        chk("hires full", 34'h1, {33'h0, fan_pwm});
        $display("test hires done");
        close_out();
    end
endmodule : test_fan_pwm_and_conversion_timing
